// ---- logic/ccs_pkg.sv ----
// Constants for the chopping clock synchronisation block.
// Assumes a 25 MHz system clock and a word-addressed Avalon-MM slave.
package ccs_pkg;
    localparam int MCLK_HZ = 25_000_000;
    localparam int MASTER_HZ = 1_000_000;
    localparam int INT_DIV_I = MCLK_HZ / MASTER_HZ;
    localparam logic [4:0] INT_DIV = INT_DIV_I[4:0];
    localparam logic [4:0] INT_HALF = INT_DIV_I[5:1];
    localparam int CHOP_DIV = 8;
    localparam int NPIN = 7;
    localparam int CLK_PIN = 4;
    localparam int AW = 4;
    // Word indices on the register bus
    localparam logic [3:0] REG_SYNC_CFG = 4'h2;
    localparam logic [3:0] REG_PIN_LEVEL = 4'h5;
    localparam logic [3:0] REG_PIN_DIR = 4'h6;
    localparam logic [3:0] REG_SPECIAL_CFG = 4'h7;
    localparam logic [3:0] REG_MCLK_CNT = 4'h8;
    // Clock configuration field positions
    localparam int DIV_LSB = 0;
    localparam int POL_BIT = 4;
    localparam int OUTSEL_BIT = 6;
    localparam int EXTEN_BIT = 0;
    localparam int CLKOUT_BIT = 1;
    // Reset values
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [6:0] PIN_RST = 7'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// ---- logic/ccs_sync.sv ----
// Two-stage synchroniser, one per bit.
// Inputs are asynchronous pins; only the second stage is read outside.
`timescale 1ns/100ps
module ccs_sync #(parameter int W = 7) (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [W-1:0] d, // Asynchronous inputs
    output logic [W-1:0] q // Synchronised outputs
);
    logic [W-1:0] s1_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (rst) begin
                    s1_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1_r[i] <= d[i];
                    q[i] <= s1_r[i];
                end
            end
        end
    endgenerate
endmodule

// ---- logic/ccs_div.sv ----
// Programmable divider of external clock edges down to master ticks.
// Ratio is two to the power of the select code; inputs are single-cycle pulses.
`timescale 1ns/100ps
module ccs_div (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic pulse, // One selected external edge
    input wire logic [2:0] code, // Divider select
    output logic tick // Master clock tick
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_eff;
    logic [2:0] code_r;
    logic [7:0] ratio;
    logic at_end;
    logic restart;
    assign ratio = 8'h01 << code;
    // A new code restarts the count, so a smaller ratio never waits for a wrap
    assign restart = (code != code_r);
    assign cnt_eff = restart ? 7'h00 : cnt_r;
    assign at_end = ({1'b0, cnt_eff} == ratio - 8'h01);
    assign tick = pulse & at_end;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 7'h00;
            code_r <= 3'h0;
        end else begin
            code_r <= code;
            if (tick)
                cnt_r <= 7'h00;
            else if (pulse)
                cnt_r <= cnt_eff + 7'h01;
            else
                cnt_r <= cnt_eff;
        end
    end

    property p_code0_pass;
        @(posedge mclk) disable iff (rst) code == 3'h0 |-> tick == pulse;
    endproperty
    a_code0_pass: assert property (p_code0_pass) else $error("code 0 must pass edges");
    property p_code5_div32;
        @(posedge mclk) disable iff (rst) (tick && code == 3'h5) |-> cnt_eff == 7'h1F;
    endproperty
    a_code5_div32: assert property (p_code5_div32) else $error("code 5 must divide by 32");
endmodule

// ---- logic/ccs_top.sv ----
// Chopping clock synchronisation with a shared clock pin and general pins.
// Function
// - Clock pin is external input or clock output
// - External clock divided by selected ratio to master
// - Chopping clock is master clock divided by eight
// - Chop transitions align to chosen external edge
// - Polarity one selects rising external edges
// - Output select picks internal master level or chopping clock
// - Code zero passes external clock undivided
// - Code five divides by thirty-two
// - External clocking only when enable bit set
// - Master clock counter readable, advances with clock
// - Direction bit one makes pin output
// - Output pin level follows level register, except the clock pin while clock output is on
// Assumes pins are asynchronous to mclk and the external clock is well below
// mclk/2; faster clocks cannot be edge-sampled and will miss edges.
`timescale 1ns/100ps
module ccs_top
    import ccs_pkg::*;
(
    input wire logic mclk, // 25 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [AW-1:0] avs_address, // Word index
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic [NPIN-1:0] pin_in, // Pin levels seen
    output logic [NPIN-1:0] pin_out, // Pin drive levels
    output logic [NPIN-1:0] pin_oe, // Pin output enables
    output logic chop_clock // Amplifier chopping clock
);
    logic [2:0] div_sel_r;
    logic chop_edge_polarity_r;
    logic clk_out_sel_r;
    logic external_clock_input_enable_r;
    logic clk_out_en_r;
    logic [NPIN-1:0] pin_dir_r;
    logic [NPIN-1:0] pin_level_r;
    logic [7:0] master_clock_counter_r;
    logic [4:0] int_cnt_r;
    logic master_lvl_r;
    logic [2:0] chop_phase_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [NPIN-1:0] pin_sync;
    logic ext_prev_r;
    logic [NPIN-1:0] pin_nxt;

    ccs_sync #(.W(NPIN)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .d(pin_in),
        .q(pin_sync)
    );

    // Bus decode: one wait state so read data come from a register
    wire req = avs_read | avs_write;
    wire done = req & ack_r;
    wire wr_go = avs_write & ack_r;
    wire lane0 = avs_byteenable[0];
    wire wr_sync = wr_go & lane0 & (avs_address == REG_SYNC_CFG);
    wire wr_level = wr_go & lane0 & (avs_address == REG_PIN_LEVEL);
    wire wr_dir = wr_go & lane0 & (avs_address == REG_PIN_DIR);
    wire wr_sf = wr_go & lane0 & (avs_address == REG_SPECIAL_CFG);
    assign avs_waitrequest = req & ~ack_r;
    assign avs_readdata = rdata_r;

    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            REG_SYNC_CFG:
                rd_mux = {25'h0, clk_out_sel_r, 1'b0, chop_edge_polarity_r, 1'b0, div_sel_r};
            REG_PIN_LEVEL:
                rd_mux = {25'h0, pin_sync};
            REG_PIN_DIR:
                rd_mux = {25'h0, pin_dir_r};
            REG_SPECIAL_CFG:
                rd_mux = {30'h0, clk_out_en_r, external_clock_input_enable_r};
            REG_MCLK_CNT:
                rd_mux = {24'h0, master_clock_counter_r};
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (avs_read & ~ack_r)
                rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_sel_r <= DIV_RST;
            chop_edge_polarity_r <= 1'b0;
            clk_out_sel_r <= 1'b0;
        end else if (wr_sync) begin
            div_sel_r <= avs_writedata[DIV_LSB+:3];
            chop_edge_polarity_r <= avs_writedata[POL_BIT];
            clk_out_sel_r <= avs_writedata[OUTSEL_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            external_clock_input_enable_r <= 1'b0;
            clk_out_en_r <= 1'b0;
        end else if (wr_sf) begin
            external_clock_input_enable_r <= avs_writedata[EXTEN_BIT];
            clk_out_en_r <= avs_writedata[CLKOUT_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_dir_r <= PIN_RST;
            pin_level_r <= PIN_RST;
        end else begin
            if (wr_dir)
                pin_dir_r <= avs_writedata[NPIN-1:0];
            if (wr_level)
                pin_level_r <= avs_writedata[NPIN-1:0];
        end
    end

    // External clock path: only live when enabled and the pin is an input
    wire ext_active = external_clock_input_enable_r & ~pin_dir_r[CLK_PIN];
    wire ext_now = pin_sync[CLK_PIN];
    wire ext_rise = ext_now & ~ext_prev_r;
    wire ext_fall = ~ext_now & ext_prev_r;
    wire ext_edge = chop_edge_polarity_r ? ext_rise : ext_fall;
    wire ext_tick;
    wire int_tick = (int_cnt_r == INT_DIV - 5'h01);
    // Divider select is only consulted in external mode
    wire master_tick = ext_active ? ext_tick : int_tick;

    ccs_div u_div (
        .mclk(mclk),
        .rst(rst),
        .pulse(ext_edge & ext_active),
        .code(div_sel_r),
        .tick(ext_tick)
    );

    always_ff @(posedge mclk) begin
        if (rst)
            ext_prev_r <= 1'b0;
        else
            ext_prev_r <= ext_now;
    end

    // Internal oscillator stand-in: 25 cycles per master period
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_cnt_r <= 5'h00;
            master_lvl_r <= 1'b0;
        end else begin
            int_cnt_r <= int_tick ? 5'h00 : int_cnt_r + 5'h01;
            master_lvl_r <= (int_cnt_r < INT_HALF);
        end
    end

    // Chop toggles every fourth master tick, so transitions sit on master ticks
    always_ff @(posedge mclk) begin
        if (rst)
            chop_phase_r <= 3'h0;
        else if (master_tick)
            chop_phase_r <= chop_phase_r + 3'h1;
    end
    assign chop_clock = chop_phase_r[2];

    always_ff @(posedge mclk) begin
        if (rst)
            master_clock_counter_r <= CNT_RST;
        else if (master_tick)
            master_clock_counter_r <= master_clock_counter_r + 8'h01;
    end

    // Pin drive: clock pin carries a clock when the special output is on
    wire clk_drive = clk_out_sel_r ? chop_phase_r[2] : master_lvl_r;
    genvar i;
    generate
        for (i = 0; i < NPIN; i++) begin : g_pin
            if (i == CLK_PIN) begin : g_clk
                assign pin_nxt[i] = clk_out_en_r ? clk_drive : pin_level_r[i];
            end else begin : g_gp
                assign pin_nxt[i] = pin_level_r[i];
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_out <= PIN_RST;
            pin_oe <= PIN_RST;
        end else begin
            pin_out <= pin_nxt;
            pin_oe <= pin_dir_r;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_int_when_off;
        !ext_active |-> master_tick == int_tick;
    endproperty
    a_int_when_off: assert property (p_int_when_off) else $error("internal clock not used");
    property p_int_period;
        int_tick |=> !int_tick [*8];
    endproperty
    a_int_period: assert property (p_int_period) else $error("internal tick too fast");
    property p_chop_on_tick;
        $changed(chop_clock) |-> $past(master_tick) && $past(chop_phase_r[1:0]) == 2'h3;
    endproperty
    a_chop_on_tick: assert property (p_chop_on_tick) else $error("chop not divide by 8");
    property p_ext_edge;
        (ext_active && master_tick) |-> ext_edge;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("master tick off external edge");
    property p_pol_rise;
        (ext_active && chop_edge_polarity_r && master_tick) |-> ext_now && !ext_prev_r;
    endproperty
    a_pol_rise: assert property (p_pol_rise) else $error("rising edge not used");
    property p_cnt_step;
        master_tick |=> master_clock_counter_r == $past(master_clock_counter_r) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not advance");
    property p_cnt_hold;
        !master_tick |=> $stable(master_clock_counter_r);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");
    property p_dir_write;
        wr_dir |=> ##1 pin_oe == $past(avs_writedata[NPIN-1:0], 2);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not applied");
    property p_level_follow;
        pin_oe[0] |-> pin_out[0] == $past(pin_level_r[0]);
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("pin level wrong");
    property p_clk_out;
        $past(clk_out_en_r) |-> pin_out[CLK_PIN] == $past(clk_drive);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock output wrong");

    c_ext_div32: cover property (ext_active && div_sel_r == 3'h5 && master_tick);
    c_chop_rise: cover property ($rose(chop_clock) && ext_active);
    c_cnt_read: cover property (done && avs_read && avs_address == REG_MCLK_CNT);
endmodule

// ---- tb/ccs_adc_model.sv ----
// Companion converter model: drives the convert strobe used as the external clock.
// Assumes the bench sets the half period in system clock cycles; the line rests low when stopped.
`timescale 1ns/100ps
module ccs_adc_model (
    input wire logic mclk, // System clock
    input wire logic run, // Strobe running
    input wire logic [7:0] half, // Half period in cycles
    output logic convert_strobe, // Strobe level
    output logic [8:0] phase // Cycles since last rising edge
);
    always_ff @(posedge mclk) begin
        if (!run) begin
            convert_strobe <= 1'b0;
            phase <= 9'h000;
        end else if (phase == {half, 1'b0} - 9'h001) begin
            convert_strobe <= 1'b1;
            phase <= 9'h000;
        end else begin
            phase <= phase + 9'h001;
            if (phase + 9'h001 == {1'b0, half}) convert_strobe <= 1'b0;
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Bench for the chopping clock block: register tasks, pin wiring and clock counting.
// Assumes one wait state per bus request and a 25-cycle internal master period.
`timescale 1ns/100ps
module testbench;
    import ccs_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, run = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, chop_clock, strobe, last_po = 1'b0, last_ch = 1'b0;
    logic [6:0] gp_in = 7'h00, pin_out, pin_oe, pin_in;
    logic [7:0] half = 8'h02;
    logic [8:0] phase, chop_ph, p1;
    int n_errors = 0, samples_checked = 0, po_rises = 0, since = 0, chop_gap = 0;
    always #20 mclk = ~mclk;
    // Pins driven by the block win; otherwise the bench and the converter drive them
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {gp_in[6:5], strobe, gp_in[3:0]});
    ccs_top u_ccs_top (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .chop_clock(chop_clock));
    ccs_adc_model u_ccs_adc_model (.mclk(mclk), .run(run), .half(half), .convert_strobe(strobe),
        .phase(phase));
    always @(negedge mclk) begin
        if (pin_out[4] && !last_po) po_rises++;
        last_po = pin_out[4];
        if (chop_clock !== last_ch) begin
            chop_gap = since;
            since = 1;
            chop_ph = phase;
        end else since++;
        last_ch = chop_clock;
    end
    task automatic end_sim;
        $display("Comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(nm, {24'h0, exp}, q);
    endtask
    // Counter read twice, w cycles apart between the completing edges
    task automatic cnt_diff(input int w, input logic [7:0] exp);
        logic [7:0] a;
        bus(1'b0, REG_MCLK_CNT, 8'h00, 4'hF);
        a = q[7:0];
        repeat (w - 3) @(posedge mclk);
        bus(1'b0, REG_MCLK_CNT, 8'h00, 4'hF);
        chk("counter step", {24'h0, exp}, {24'h0, q[7:0] - a});
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        foreach (q[i]) if (i < 5) rd_chk("reset value", i == 4 ? 4'hF : REG_SYNC_CFG + 4'(i), 8'h00);
        $display("test reset done");
        gp_in <= 7'h2A;
        wr(REG_PIN_DIR, 8'h01);
        wr(REG_PIN_LEVEL, 8'h7F);
        bus(1'b1, REG_PIN_DIR, 8'h7F, 4'h0);
        rd_chk("direction", REG_PIN_DIR, 8'h01);
        rd_chk("pin levels", REG_PIN_LEVEL, 8'h2B);
        @(negedge mclk);
        chk("pin enables", {25'h0, pin_oe}, 32'h01);
        chk("pin zero", {31'h0, pin_out[0]}, 32'h1);
        wr(REG_PIN_LEVEL, 8'h00);
        repeat (2) @(negedge mclk);
        chk("pin zero", {31'h0, pin_out[0]}, 32'h0);
        $display("test pins done");
        run <= 1'b1;
        wr(REG_SYNC_CFG, 8'h15);
        cnt_diff(250, 8'd10);
        $display("test internal done");
        wr(REG_SPECIAL_CFG, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(REG_SYNC_CFG, 8'h10 | 8'(c));
            repeat (8 << c) @(posedge mclk);
            cnt_diff(40 << c, 8'd10);
        end
        $display("test dividers done");
        half <= 8'h05;
        wr(REG_SYNC_CFG, 8'h10);
        repeat (400) @(posedge mclk);
        p1 = chop_ph;
        chk("chop half period", 32'(chop_gap), 32'd40);
        wr(REG_SYNC_CFG, 8'h00);
        repeat (400) @(posedge mclk);
        chk("chop edge phase", 32'(chop_ph), 32'((p1 + 5) % 10));
        $display("test polarity done");
        run <= 1'b0;
        wr(REG_SPECIAL_CFG, 8'h02);
        wr(REG_PIN_DIR, 8'h10);
        repeat (60) @(posedge mclk);
        po_rises = 0;
        repeat (250) @(posedge mclk);
        chk("master out", 32'(po_rises), 32'd10);
        chk("clock pin enable", {31'h0, pin_oe[4]}, 32'h1);
        wr(REG_SYNC_CFG, 8'h40);
        repeat (250) @(posedge mclk);
        po_rises = 0;
        repeat (2000) @(posedge mclk);
        chk("chop out", 32'(po_rises), 32'd10);
        $display("test clock out done");
        end_sim;
    end
endmodule
